/* src/input_terminal_command_decoder.sv */
`timescale 1ns/1ps
`include "input_terminal_cfg.svh"

module input_terminal_command_decoder #(
  parameter int N_IN          = 7,
  parameter int DW            = 16,
  parameter int SAMPLE_CYCLES = `SAMPLE_CYCLES
) (
  input  wire logic          clock,
  input  wire logic          rst_b,
  input  wire logic          clk_en,
  input  wire logic [N_IN-1:0] terminal_raw,
  input  wire logic [7:0]    addr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic          wr,
  input  wire logic          rd,
  output logic [DW-1:0]      rdata,
  output logic               run_forward,
  output logic               run_reverse,
  output logic               swing_clear,
  output logic               swing_restart,
  output logic               seq_normal,
  output logic               seq_zero_freq,
  output logic               seq_hold_timer,
  output logic               seq_speed_track,
  output logic               seq_clear,
  output logic               seq_restart,
  output logic               torque_control,
  output logic               torque_inhibit,
  output logic               freq_source_b,
  output logic               ext_pulse,
  output logic               open_collector_out_one,
  output logic               open_collector_out_two,
  output logic               relay_out_one
);
  localparam int TW = $clog2(SAMPLE_CYCLES + 1);

  logic [N_IN-1:0]   sync_a;
  logic [N_IN-1:0]   sync_b;
  logic [N_IN-1:0]   filtered;
  logic [N_IN-1:0]   act;
  logic [N_IN*6-1:0] codes;
  logic [7:0]        input_filter_count;
  logic [7:0]        powerup_run_guard;
  logic [7:0]        input_polarity_mask;
  logic [7:0]        run_wiring_mode;
  logic [7:0]        function_control;
  logic [DW-1:0]     count_preset;
  logic [3:0]        filt_limit;
  logic [TW-1:0]     tick_cnt;
  logic              tick;
  logic [3:0]        settle;
  logic              armed;
  logic [DW-1:0]     counter;
  logic [DW-1:0]     timer;
  logic              timing;
  logic [DW-1:0]     length;
  logic              b_run;
  input_terminal_pkg::run_state_e state;
  input_terminal_pkg::run_state_e next_state;

  // ==========================================
  // Function decode over all terminals, except pulse frequency and length count, which decode the HS terminal only
  function automatic logic term_fn(input logic [N_IN*6-1:0] c, input logic [N_IN-1:0] a,
                                   input input_terminal_pkg::func_code_t f);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < N_IN; i++) begin
      if (c[i*6 +: 6] == f && a[i]) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  logic forward_cmd_input, rev, stp, f37, f38, f39, f40, f41, f42, f43, f44;
  logic f45, f46, f47, f48, f49, f60, f61, f62, f64;
  logic p_fwd, p_rev, p37, p39, p40, p42, p43, p45, p47, p64;
  logic hs_act;

  assign hs_act = act[`HS_TERMINAL];
  assign forward_cmd_input = term_fn(codes, act, `FN_FORWARD);
  assign rev = term_fn(codes, act, `FN_REVERSE);
  assign stp = term_fn(codes, act, `FN_STOP_ENABLE);
  assign f37 = term_fn(codes, act, `FN_SWING_RESET);
  assign f38 = term_fn(codes, act, `FN_SEQ_ENABLE);
  assign f39 = term_fn(codes, act, `FN_SEQ_PAUSE);
  assign f40 = term_fn(codes, act, `FN_SEQ_RESET);
  assign f41 = term_fn(codes, act, `FN_COUNT_CLEAR);
  assign f42 = term_fn(codes, act, `FN_COUNT_TRIG);
  assign f43 = term_fn(codes, act, `FN_TIMER_TRIG);
  assign f44 = term_fn(codes, act, `FN_TIMER_CLEAR);
  assign f45 = hs_act && codes[`HS_TERMINAL*6 +: 6] == `FN_PULSE_FREQ;
  assign f46 = term_fn(codes, act, `FN_LENGTH_CLEAR);
  assign f47 = hs_act && codes[`HS_TERMINAL*6 +: 6] == `FN_LENGTH_COUNT;
  assign f48 = term_fn(codes, act, `FN_TORQUE_SWITCH);
  assign f49 = term_fn(codes, act, `FN_TORQUE_INHIBIT);
  assign f60 = term_fn(codes, act, `FN_INTERLOCK_1);
  assign f61 = term_fn(codes, act, `FN_INTERLOCK_2);
  assign f62 = term_fn(codes, act, `FN_INTERLOCK_3);
  assign f64 = term_fn(codes, act, `FN_SOURCE_B_RUN);

  // ==========================================
  // Input synchronisers, sample tick, filters
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      sync_a <= '0;
      sync_b <= '0;
    end else if (clk_en) begin
      sync_a <= terminal_raw;
      sync_b <= sync_a;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else if (clk_en) begin
      tick     <= tick_cnt == TW'(SAMPLE_CYCLES - 1);
      tick_cnt <= (tick_cnt == TW'(SAMPLE_CYCLES - 1)) ? '0 : tick_cnt + TW'(1);
    end
  end

  always_comb begin
    if (input_filter_count[3:0] < `FILTER_MIN || input_filter_count > 8'(`FILTER_MAX)) begin
      filt_limit = `FILTER_MAX;
    end else begin
      filt_limit = input_filter_count[3:0];
    end
  end

  genvar g;
  generate
    for (g = 0; g < N_IN; g++) begin : gen_filter
      input_debounce u_flt (
        .clock  (clock),
        .rst_b  (rst_b),
        .clk_en (clk_en),
        .sample (tick),
        .raw    (sync_b[g]),
        .limit  (filt_limit),
        .level  (filtered[g])
      );
    end
  endgenerate

  // Raw 1 is closed to common
  assign act = filtered ^ input_polarity_mask[N_IN-1:0];

  // ==========================================
  // Register writes
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      input_filter_count  <= `RST_FILTER;
      powerup_run_guard   <= `RST_GUARD;
      input_polarity_mask <= `RST_POLARITY;
      run_wiring_mode     <= `RST_WIRING;
      function_control    <= `RST_CONTROL;
      count_preset        <= `RST_PRESET;
      codes               <= '0;
    end else if (clk_en && wr) begin
      if (addr == `OFS_FILTER) begin
        input_filter_count <= wdata[7:0];
      end else if (addr == `OFS_GUARD) begin
        powerup_run_guard <= wdata[7:0];
      end else if (addr == `OFS_POLARITY) begin
        input_polarity_mask <= {1'b0, wdata[6:0]};
      end else if (addr == `OFS_WIRING) begin
        run_wiring_mode <= wdata[7:0];
      end else if (addr == `OFS_CONTROL) begin
        function_control <= wdata[7:0];
      end else if (addr == `OFS_PRESET) begin
        count_preset <= wdata;
      end else if (addr >= `OFS_FUNC_BASE && addr <= `OFS_FUNC_LAST) begin
        codes[(addr - `OFS_FUNC_BASE)*6 +: 6] <= wdata[5:0];
      end
    end
  end

  // ==========================================
  // Register reads
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rdata <= '0;
    end else if (clk_en) begin
      rdata <= '0;
      if (rd) begin
        if (addr == `OFS_FILTER) begin
          rdata <= DW'(input_filter_count);
        end else if (addr == `OFS_GUARD) begin
          rdata <= DW'(powerup_run_guard);
        end else if (addr == `OFS_POLARITY) begin
          rdata <= DW'(input_polarity_mask);
        end else if (addr == `OFS_WIRING) begin
          rdata <= DW'(run_wiring_mode);
        end else if (addr == `OFS_CONTROL) begin
          rdata <= DW'(function_control);
        end else if (addr == `OFS_PRESET) begin
          rdata <= count_preset;
        end else if (addr >= `OFS_FUNC_BASE && addr <= `OFS_FUNC_LAST) begin
          rdata <= DW'(codes[(addr - `OFS_FUNC_BASE)*6 +: 6]);
        end else if (addr == `OFS_LEVELS) begin
          rdata <= DW'(act);
        end else if (addr == `OFS_RUN_STATUS) begin
          rdata <= DW'({timing, b_run, armed, state});
        end else if (addr == `OFS_COUNTER) begin
          rdata <= counter;
        end else if (addr == `OFS_TIMER) begin
          rdata <= timer;
        end else if (addr == `OFS_LENGTH) begin
          rdata <= length;
        end
      end
    end
  end

  // ==========================================
  // Edge history
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      {p_fwd, p_rev, p37, p39, p40, p42, p43, p45, p47, p64} <= '0;
    end else if (clk_en) begin
      {p_fwd, p_rev, p37, p39, p40, p42, p43, p45, p47, p64} <=
        {forward_cmd_input, rev, f37, f39, f40, f42, f43, f45, f47, f64};
    end
  end

  // ==========================================
  // Power-up run guard
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      settle <= 4'h0;
      armed  <= 1'b1;
    end else if (clk_en) begin
      if (tick && settle != `SETTLE_TICKS) begin
        settle <= settle + 4'h1;
      end
      if (powerup_run_guard[0]) begin
        armed <= 1'b0;
      end else if (settle == `SETTLE_TICKS && !forward_cmd_input && !rev) begin
        armed <= 1'b0;
      end
    end
  end

  // ==========================================
  // Run command decode
  always_comb begin
    next_state = state;
    case (run_wiring_mode[1:0])
      `WIRE_TWO_1, `WIRE_TWO_2: begin
        if (forward_cmd_input && rev) begin
          next_state = input_terminal_pkg::reverse;
        end else if (forward_cmd_input) begin
          next_state = input_terminal_pkg::forward;
        end else begin
          next_state = input_terminal_pkg::stopped;
        end
      end
      `WIRE_THREE_1: begin
        if (!stp) begin
          next_state = input_terminal_pkg::stopped;
        end else if (forward_cmd_input && !p_fwd) begin
          next_state = input_terminal_pkg::forward;
        end else if (rev && !p_rev) begin
          next_state = input_terminal_pkg::reverse;
        end
      end
      default: begin
        if (!stp) begin
          next_state = input_terminal_pkg::stopped;
        end else if (state == input_terminal_pkg::stopped) begin
          if (forward_cmd_input && !p_fwd) begin
            next_state = input_terminal_pkg::forward;
          end
        end else if (rev) begin
          next_state = input_terminal_pkg::reverse;
        end else begin
          next_state = input_terminal_pkg::forward;
        end
      end
    endcase
    if (armed) begin
      next_state = input_terminal_pkg::stopped;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state <= input_terminal_pkg::stopped;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  logic running;
  assign running = state != input_terminal_pkg::stopped || b_run;

  // ==========================================
  // Source B switch and start
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      b_run         <= 1'b0;
      freq_source_b <= 1'b0;
    end else if (clk_en) begin
      freq_source_b <= f64;
      if (!f64) begin
        b_run <= 1'b0;
      end else if (!p64 && !running) begin
        b_run <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      run_forward <= 1'b0;
      run_reverse <= 1'b0;
    end else if (clk_en) begin
      run_forward <= state == input_terminal_pkg::forward ||
                     (state == input_terminal_pkg::stopped && b_run);
      run_reverse <= state == input_terminal_pkg::reverse;
    end
  end

  // ==========================================
  // Swing and sequencer control
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      swing_clear     <= 1'b0;
      swing_restart   <= 1'b0;
      seq_normal      <= 1'b0;
      seq_zero_freq   <= 1'b0;
      seq_hold_timer  <= 1'b0;
      seq_speed_track <= 1'b0;
      seq_clear       <= 1'b0;
      seq_restart     <= 1'b0;
    end else if (clk_en) begin
      swing_clear     <= f37;
      swing_restart   <= p37 && !f37;
      seq_normal      <= running && !f39 &&
                         (!function_control[`CTL_SEQ_MANUAL] || f38);
      seq_zero_freq   <= running && (f39 ||
                         (function_control[`CTL_SEQ_MANUAL] && !f38));
      seq_hold_timer  <= f39;
      seq_speed_track <= p39 && !f39 && running;
      seq_clear       <= function_control[`CTL_SEQ_MODE] && !running && f40;
      seq_restart     <= function_control[`CTL_SEQ_MODE] && p40 && !f40;
    end
  end

  // ==========================================
  // Pulse counter
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      counter <= `RST_PRESET;
    end else if (clk_en) begin
      if (f41) begin
        counter <= count_preset;
      end else if (f42 && !p42) begin
        if (function_control[`CTL_COUNT_DOWN]) begin
          counter <= counter - DW'(1);
        end else begin
          counter <= counter + DW'(1);
        end
      end
    end
  end

  // ==========================================
  // Timer in sample ticks
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      timer  <= '0;
      timing <= 1'b0;
    end else if (clk_en) begin
      if (f44) begin
        timer  <= '0;
        timing <= 1'b0;
      end else begin
        if (f43 && !p43) begin
          timing <= 1'b1;
        end
        if (timing && tick && timer != '1) begin
          timer <= timer + DW'(1);
        end
      end
    end
  end

  // ==========================================
  // Length count and pulse frequency input
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      length    <= '0;
      ext_pulse <= 1'b0;
    end else if (clk_en) begin
      ext_pulse <= f45 && !p45;
      if (f46) begin
        length <= '0;
      end else if (f47 && !p47 && length != '1) begin
        length <= length + DW'(1);
      end
    end
  end

  // ==========================================
  // Torque switch and interlocks
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      torque_control         <= 1'b0;
      torque_inhibit         <= 1'b0;
      open_collector_out_one <= 1'b0;
      open_collector_out_two <= 1'b0;
      relay_out_one          <= 1'b0;
    end else if (clk_en) begin
      torque_control         <= function_control[`CTL_TORQUE_TERM] && f48 && !f49;
      torque_inhibit         <= f49;
      open_collector_out_one <= f60;
      open_collector_out_two <= f61;
      relay_out_one          <= f62;
    end
  end
endmodule

/* src/input_terminal_cfg.svh */
`ifndef INPUT_TERMINAL_CFG_SVH
`define INPUT_TERMINAL_CFG_SVH

// ==========================================
// Timing
`define CLOCK_PERIOD_NS   100'd10
`define SAMPLE_PERIOD_NS  200000
`define SAMPLE_CYCLES     (`SAMPLE_PERIOD_NS / 10)
`define SETTLE_TICKS      4'hC

// ==========================================
// Register offsets
`define OFS_FILTER        8'h00
`define OFS_GUARD         8'h01
`define OFS_POLARITY      8'h02
`define OFS_WIRING        8'h03
`define OFS_CONTROL       8'h04
`define OFS_PRESET        8'h05
`define OFS_FUNC_BASE     8'h10
`define OFS_FUNC_LAST     8'h16
`define OFS_LEVELS        8'h20
`define OFS_RUN_STATUS    8'h21
`define OFS_COUNTER       8'h22
`define OFS_TIMER         8'h23
`define OFS_LENGTH        8'h24

// ==========================================
// Reset values and limits
`define RST_FILTER        8'h05
`define RST_GUARD         8'h00
`define RST_POLARITY      8'h00
`define RST_WIRING        8'h00
`define RST_CONTROL       8'h00
`define RST_PRESET        16'h0000
`define RST_FUNC          6'h00
`define FILTER_MIN        4'h1
`define FILTER_MAX        4'hA

// ==========================================
// Control register bits
`define CTL_COUNT_DOWN    0
`define CTL_TORQUE_TERM   1
`define CTL_SEQ_MANUAL    2
`define CTL_SEQ_MODE      3

// ==========================================
// Wiring modes
`define WIRE_TWO_1        2'h0
`define WIRE_TWO_2        2'h1
`define WIRE_THREE_1      2'h2
`define WIRE_THREE_2      2'h3

// ==========================================
// Terminal function codes
`define FN_FORWARD        6'h01
`define FN_REVERSE        6'h02
`define FN_STOP_ENABLE    6'h03
`define FN_SWING_RESET    6'h25
`define FN_SEQ_ENABLE     6'h26
`define FN_SEQ_PAUSE      6'h27
`define FN_SEQ_RESET      6'h28
`define FN_COUNT_CLEAR    6'h29
`define FN_COUNT_TRIG     6'h2A
`define FN_TIMER_TRIG     6'h2B
`define FN_TIMER_CLEAR    6'h2C
`define FN_PULSE_FREQ     6'h2D
`define FN_LENGTH_CLEAR   6'h2E
`define FN_LENGTH_COUNT   6'h2F
`define FN_TORQUE_SWITCH  6'h30
`define FN_TORQUE_INHIBIT 6'h31
`define FN_INTERLOCK_1    6'h3C
`define FN_INTERLOCK_2    6'h3D
`define FN_INTERLOCK_3    6'h3E
`define FN_SOURCE_B_RUN   6'h40
`define HS_TERMINAL       5

`endif

/* src/input_terminal_pkg.sv */
package input_terminal_pkg;
  // ==========================================
  // Types
  typedef enum logic [1:0] {stopped, forward, reverse} run_state_e;
  typedef logic [5:0] func_code_t;
endpackage

/* src/input_debounce.sv */
`timescale 1ns/1ps
`include "input_terminal_cfg.svh"

module input_debounce (
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       clk_en,
  input  wire logic       sample,
  input  wire logic       raw,
  input  wire logic [3:0] limit,
  output logic            level
);
  logic [3:0] held;

  // ==========================================
  // Accept a new level after limit equal samples
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      held  <= 4'h0;
      level <= 1'b0;
    end else if (clk_en && sample) begin
      if (raw == level) begin
        held <= 4'h0;
      end else if (held + 4'h1 >= limit) begin
        held  <= 4'h0;
        level <= raw;
      end else begin
        held <= held + 4'h1;
      end
    end
  end
endmodule

/* tb/input_terminal_command_decoder_asserts.sv */
`timescale 1ns/1ps
// ==========
// Port checks
module input_terminal_command_decoder_asserts #(
  parameter int DW = 16
) (
  input wire logic          clock,
  input wire logic          rst_b,
  input wire logic          rd,
  input wire logic [DW-1:0] rdata,
  input wire logic          run_forward,
  input wire logic          run_reverse,
  input wire logic          swing_clear,
  input wire logic          swing_restart,
  input wire logic          seq_normal,
  input wire logic          seq_zero_freq,
  input wire logic          seq_hold_timer,
  input wire logic          seq_speed_track,
  input wire logic          seq_restart,
  input wire logic          torque_control,
  input wire logic          torque_inhibit,
  input wire logic          ext_pulse,
  input wire logic          open_collector_out_one
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  chk_rdata_idle: assert property (!$past(rd) |-> rdata == '0)
    else $error("rdata not idle");
  chk_run_excl: assert property (!(run_forward && run_reverse))
    else $error("both directions");
  chk_swing_release: assert property (swing_restart |-> $fell(swing_clear))
    else $error("swing restart without release");
  chk_inhibit_wins: assert property (torque_inhibit |-> !torque_control)
    else $error("torque while inhibited");
  chk_seq_excl: assert property (seq_normal |-> !seq_zero_freq)
    else $error("normal and zero freq together");
  chk_pause_zero: assert property (seq_hold_timer && (run_forward || run_reverse) |-> seq_zero_freq)
    else $error("pause without zero freq");
  chk_ext_pulse: assert property (ext_pulse |=> !ext_pulse [*2])
    else $error("ext pulse too long");
  chk_track_pulse: assert property (seq_speed_track |=> !seq_speed_track)
    else $error("track pulse too long");
  chk_restart_pulse: assert property (seq_restart |=> !seq_restart)
    else $error("restart pulse too long");
  chk_reset_quiet: assert property (disable iff (1'b0) !rst_b |=>
    !run_forward && !run_reverse && !open_collector_out_one && rdata == '0)
    else $error("outputs active after reset");
  cover property (run_reverse);
  cover property (swing_restart);
  cover property (open_collector_out_one);
  cover property (seq_speed_track);
endmodule

/* tb/terminal_switches.sv */
`timescale 1ns/1ps
// ==========
// Contacts on the terminals, settle one cycle after command
module terminal_switches (
  input  wire logic       clock,
  input  wire logic [6:0] closed,
  output logic      [6:0] terminal_raw
);
  always @(posedge clock) terminal_raw <= closed;
endmodule

/* tb/input_terminal_command_decoder_tb.sv */
`timescale 1ns/1ps
// ==========
// Bench top
module input_terminal_command_decoder_tb;
  logic        clock, rst_b, wr, rd, forward_cmd_input, rev, swc, tqi, oc1, oc2, rl1, sqz, sqn, sqc, fsb;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata, fnv;
  logic [6:0]  closed, raw;
  logic [5:0]  fcs [9] = '{6'h3C, 6'h3D, 6'h3E, 6'h25, 6'h31, 6'h27, 6'h28, 6'h30, 6'h40};
  logic [7:0]  fex [9] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h00, 8'h20, 8'h00, 8'hC0};
  int          steps[$] = '{8'h72, 8'h03, 8'h13, 8'h0B, 8'h00, 8'h2B, 8'h0B, 8'h01, 8'h1A,
                            8'h13, 8'h20, 8'h73, 8'h2B, 8'h18, 8'h13, 8'h0B, 8'h01, 8'h1A,
                            8'h11, 8'h20, 8'h13};
  int          n_errors, n_compared, cyc, seed, cnt, n;

  input_terminal_command_decoder #(.SAMPLE_CYCLES(4)) input_terminal_command_decoder_inst (
    .clock(clock), .rst_b(rst_b), .clk_en(1'b1), .terminal_raw(raw), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .run_forward(forward_cmd_input), .run_reverse(rev),
    .swing_clear(swc), .swing_restart(), .seq_normal(sqn), .seq_zero_freq(sqz), .seq_hold_timer(),
    .seq_speed_track(), .seq_clear(sqc), .seq_restart(), .torque_control(), .torque_inhibit(tqi),
    .freq_source_b(fsb), .ext_pulse(), .open_collector_out_one(oc1), .open_collector_out_two(oc2),
    .relay_out_one(rl1));
  assign fnv = {8'h0, fsb, forward_cmd_input, sqc, tqi, swc, rl1, oc2, oc1};
  terminal_switches terminal_switches_inst (.clock(clock), .closed(closed), .terminal_raw(raw));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      end_sim();
    end
  end

  task end_sim();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task check(input string nm, input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
    end
  endtask
  task hold(input int c);
    repeat (c) @(posedge clock);
  endtask
  task wreg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task rreg(input logic [7:0] a, input logic [15:0] e);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 check("reg", rdata, e);
  endtask
  task press(input int t, input logic v);
    @(posedge clock);
    closed[t] <= v;
    hold(60);
  endtask
  task run_chk(input int d);
    check("run", {14'h0, rev, forward_cmd_input}, d[15:0]);
  endtask
  // Two-wire truth table: forward alone runs forward, both run reverse
  function int exp2(input logic f, input logic r);
    return f ? (r ? 2 : 1) : 0;
  endfunction

  initial begin
    {rst_b, wr, rd, addr, wdata} = '0;
    closed = 7'h01;
    seed = 45;
    hold(5);
    rst_b <= 1'b1;
    rreg(8'h00, 16'h0005);
    rreg(8'h01, 16'h0000);
    rreg(8'h03, 16'h0000);
    rreg(8'h7F, 16'h0000);
    wreg(8'h02, 16'h00FF);
    rreg(8'h02, 16'h007F);
    wreg(8'h02, 16'h0000);
    wreg(8'h00, 16'h0003);
    wreg(8'h10, 16'h0001);
    hold(60);
    run_chk(0);
    press(0, 1'b0);
    @(posedge clock);
    closed[0] <= 1'b1;
    hold(6);
    rreg(8'h20, 16'h0000);
    hold(40);
    rreg(8'h20, 16'h0001);
    run_chk(1);
    wreg(8'h11, 16'h0002);
    wreg(8'h12, 16'h0003);
    for (int m = 0; m < 2; m++) begin
      wreg(8'h03, m[15:0]);
      for (int k = 0; k < 4; k++) begin
        @(posedge clock);
        closed[1:0] <= k[1:0];
        hold(60);
        run_chk(exp2(k[0], k[1]));
      end
    end
    foreach (steps[i]) begin
      if (steps[i] / 16 == 7) wreg(8'h03, 16'(steps[i] % 8));
      else press(steps[i] / 16, steps[i][3]);
      if (steps[i] / 16 != 7 && steps[i] % 8 != 3) run_chk(steps[i] % 8);
    end
    wreg(8'h13, 16'h002A);
    wreg(8'h14, 16'h0029);
    wreg(8'h05, 16'h0010);
    press(4, 1'b1);
    press(4, 1'b0);
    cnt = 16;
    rreg(8'h22, 16'h0010);
    for (int d = 0; d < 2; d++) begin
      wreg(8'h04, d[15:0]);
      n = 1 + ($random(seed) & 7);
      repeat (n) begin
        press(3, 1'b1);
        press(3, 1'b0);
      end
      cnt = d ? cnt - n : cnt + n;
      rreg(8'h22, cnt[15:0]);
    end
    wreg(8'h15, 16'h002F);
    wreg(8'h13, 16'h002F);
    repeat (2) begin
      press(3, 1'b1);
      press(3, 1'b0);
      press(5, 1'b1);
      press(5, 1'b0);
    end
    rreg(8'h24, 16'h0002);
    wreg(8'h14, 16'h002E);
    press(4, 1'b1);
    rreg(8'h24, 16'h0000);
    press(4, 1'b0);
    wreg(8'h04, 16'h000C);
    for (int i = 0; i < 9; i++) begin
      wreg(8'h16, {10'h0, fcs[i]});
      press(6, 1'b1);
      check("fn", fnv, 16'(fex[i]));
      press(6, 1'b0);
    end
    wreg(8'h15, 16'h0027);
    press(6, 1'b1);
    check("seq", {14'h0, sqz, sqn}, 16'h0002);
    wreg(8'h04, 16'h0008);
    hold(2);
    check("seq", {14'h0, sqz, sqn}, 16'h0001);
    press(5, 1'b1);
    check("seq", {14'h0, sqz, sqn}, 16'h0002);
    press(5, 1'b0);
    press(6, 1'b0);
    wreg(8'h15, 16'h002D);
    press(5, 1'b1);
    press(5, 1'b0);
    wreg(8'h16, 16'h003C);
    wreg(8'h02, 16'h0040);
    hold(60);
    check("pol", {15'h0, oc1}, 16'h0001);
    end_sim();
  end
endmodule

bind input_terminal_command_decoder input_terminal_command_decoder_asserts #(.DW(DW)) chk_inst (
  .clock(clock), .rst_b(rst_b), .rd(rd), .rdata(rdata), .run_forward(run_forward),
  .run_reverse(run_reverse), .swing_clear(swing_clear), .swing_restart(swing_restart),
  .seq_normal(seq_normal), .seq_zero_freq(seq_zero_freq), .seq_hold_timer(seq_hold_timer),
  .seq_speed_track(seq_speed_track), .seq_restart(seq_restart),
  .torque_control(torque_control), .torque_inhibit(torque_inhibit), .ext_pulse(ext_pulse),
  .open_collector_out_one(open_collector_out_one));
